// file: core/operand_decoder_defines.vh
// Constants for the operand field decoder
// Contract
// RULE_01 - Source mode field picks direct, indirect, post/pre decrement or increment; one unused.
// RULE_02 - Destination mode field picks the same six modes for the destination register.
// RULE_03 - Unused destination mode forces a reset request instead of the operation.
// RULE_04 - Source offset field: 000..101 as usual, 11x adds base register.
// RULE_05 - Destination offset field decodes alike; 11x adds base register to destination.
// RULE_06 - Multiply destination: even pair 1:0..13:12, its even register, accumulator A or B.
// RULE_07 - X codes 0000..0011 read via register 8, post-add 0,2,4,6; 0100 none.
// RULE_08 - X codes 0101..0111 read via register 8, post-subtract 6,4,2.
// RULE_09 - X codes 1000..1011 via register 9 post-add; 1100 adds 12; 1101..1111 subtract.
// RULE_10 - Y codes 0000..0011 via register 10 post-add; 0100 none; 0101..0111 subtract.
// RULE_11 - Y codes 1000..1011 via register 11 post-add; 1100 reads at 11 plus 12.
// RULE_12 - X prefetch destination codes 00..11 map to registers 4..7.
// RULE_13 - Y prefetch destination codes 00..11 map to registers 4..7.
// RULE_14 - Square operand codes 00..11 select register 4..7 times itself.
// RULE_15 - Pair operand field decodes six register pairs; 011 and 111 invalid.
// RULE_16 - Write-back: 00 to register 13, 01 indirect post-add 2, 10 none, 11 invalid.
// RULE_17 - Page target: 00 read page, 01 write page, 10 table page, 11 reset.
// RULE_18 - Accumulator select bit: 0 targets accumulator A, 1 accumulator B.
// RULE_19 - Base register select 0000..1111 maps linearly to registers 0..15.
// RULE_20 - Invalid pair or write-back codes raise the same illegal-opcode reset.
`ifndef OPERAND_DECODER_DEFINES_VH
`define OPERAND_DECODER_DEFINES_VH

// ==========================================================
// Addressing mode codes
`define AM_DIRECT   3'h0
`define AM_INDIRECT 3'h1
`define AM_POSTDEC  3'h2
`define AM_POSTINC  3'h3
`define AM_PREDEC   3'h4
`define AM_PREINC   3'h5
`define AM_OFFSET   3'h6
`define AM_UNUSED   3'h7

// ==========================================================
// Prefetch and write-back codes
`define PF_NONE_CODE   3'h4
`define PF_OFS_CODE    3'h4
`define WB_DIRECT      2'h0
`define WB_INDIRECT    2'h1
`define WB_NONE        2'h2
`define WB_INVALID     2'h3
`define PAGE_INVALID   2'h3
`define PAIR_BAD_LOW   2'h3

// ==========================================================
// Working register numbers
`define REG_W4   4'h4
`define REG_W5   4'h5
`define REG_W6   4'h6
`define REG_W7   4'h7
`define WORKING_REG_8  4'h8
`define REG_W9   4'h9
`define REG_W10  4'hA
`define REG_W11  4'hB
`define REG_W12  4'hC
`define WORKING_REG_13 4'hD
`define MUL_ACC_A 4'hE
`define MUL_ACC_B 4'hF
`define WB_STEP  4'h2

// ==========================================================
// Wishbone register map (byte addresses) and reset values
`define ADDR_CTRL   4'h0
`define ADDR_STATUS 4'h4
`define ADDR_COUNT  4'h8
`define CTRL_RESET  1'h1
`define CTRL_EN_BIT 0
`define ST_DST_BIT  0
`define ST_PAIR_BIT 1
`define ST_WB_BIT   2
`define ST_PAGE_BIT 3

`endif

// file: core/operand_field_decoder.v
// Operand field decoder with Wishbone control and status registers
`timescale 1ns/1ps
`default_nettype none
`include "operand_decoder_defines.vh"

module operand_field_decoder (
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone classic slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Instruction fields from fetch
    input  wire        dec_valid_i,
    input  wire        src_ofs_form_i,
    input  wire        dst_ofs_form_i,
    input  wire        dst_mode_used_i,
    input  wire [2:0]  src_mode_i,
    input  wire [2:0]  dst_mode_i,
    input  wire [3:0]  base_sel_i,
    input  wire [3:0]  mul_dst_i,
    input  wire [3:0]  x_pf_op_i,
    input  wire [1:0]  x_prefetch_dest_field_i,
    input  wire [3:0]  y_pf_op_i,
    input  wire [1:0]  y_prefetch_dest_field_i,
    input  wire        square_form_i,
    input  wire [1:0]  square_operand_field_i,
    input  wire [2:0]  pair_operand_field_i,
    input  wire        mul_used_i,
    input  wire [1:0]  writeback_select_field_i,
    input  wire        wb_used_i,
    input  wire [1:0]  page_target_field_i,
    input  wire        page_used_i,
    input  wire        acc_sel_i,
    // Decoded controls
    output reg         dec_valid_o,
    output reg  [2:0]  src_am_o,
    output reg  [2:0]  dst_am_o,
    output reg  [3:0]  base_reg_o,
    output reg  [3:0]  mul_dst_reg_o,
    output reg         mul_dst_pair_o,
    output reg         mul_dst_acc_o,
    output reg         x_pf_en_o,
    output reg  [3:0]  x_pf_addr_reg_o,
    output reg         x_pf_add_w12_o,
    output reg  [3:0]  x_pf_adj_o,
    output reg  [3:0]  x_pf_dest_o,
    output reg         y_pf_en_o,
    output reg  [3:0]  y_pf_addr_reg_o,
    output reg         y_pf_add_w12_o,
    output reg  [3:0]  y_pf_adj_o,
    output reg  [3:0]  y_pf_dest_o,
    output reg  [3:0]  mul_a_reg_o,
    output reg  [3:0]  mul_b_reg_o,
    output reg         wb_en_o,
    output reg         wb_indirect_o,
    output reg  [3:0]  wb_reg_o,
    output reg  [3:0]  wb_adj_o,
    output reg  [2:0]  page_reg_sel_o,
    output reg         acc_b_sel_o,
    output reg         reset_req_o
);

// ==========================================================
// Functions
// Offset form keeps 11x as register offset; plain form leaves 11x unused
function [2:0] am_decode;
    input [2:0] code;
    input       ofs_form;
    begin
        if (code[2:1] == 2'h3) begin
            am_decode = ofs_form ? `AM_OFFSET : `AM_UNUSED; // see RULE_04 RULE_05
        end else begin
            am_decode = code; // see RULE_01 RULE_02
        end
    end
endfunction

// Post-adjust as a 4-bit two's complement step: +0,+2,+4,+6 or -6,-4,-2
function [3:0] pf_adjust;
    input [2:0] low;
    begin
        case (low)
            3'h0:    pf_adjust = 4'h0;
            3'h1:    pf_adjust = 4'h2;
            3'h2:    pf_adjust = 4'h4;
            3'h3:    pf_adjust = 4'h6;
            3'h5:    pf_adjust = 4'hA;
            3'h6:    pf_adjust = 4'hC;
            3'h7:    pf_adjust = 4'hE;
            default: pf_adjust = 4'h0;
        endcase
    end
endfunction

// Destination fields of both prefetches share the 4..7 window
function [3:0] w4_to_w7;
    input [1:0] code;
    begin
        w4_to_w7 = {2'h1, code};
    end
endfunction

// Register read mux; unmapped offsets read as zero, never stale data
function [31:0] read_word;
    input [3:0]  adr;
    input        en;
    input [3:0]  cause;
    input [15:0] count;
    begin
        case (adr)
            `ADDR_CTRL:   read_word = {31'h00000000, en};
            `ADDR_STATUS: read_word = {28'h0000000, cause};
            `ADDR_COUNT:  read_word = {16'h0000, count};
            default:      read_word = 32'h00000000;
        endcase
    end
endfunction

// ==========================================================
// Control and status registers
reg        dec_en;
reg [3:0]  ill_cause;
reg [15:0] ill_count;

wire bus_req   = cyc_i & stb_i & ~ack_o;
// Writes land on the edge at which the master samples ack high
wire bus_write = cyc_i & stb_i & we_i & ack_o;
wire do_dec    = dec_valid_i & dec_en;

// ==========================================================
// Combinational decode
reg [2:0] next_src_am;
reg [2:0] next_dst_am;
reg [3:0] next_mul_dst;
reg       next_mul_pair;
reg       next_mul_acc;
reg       next_x_en;
reg [3:0] next_x_reg;
reg       next_x_w12;
reg [3:0] next_x_adj;
reg       next_y_en;
reg [3:0] next_y_reg;
reg       next_y_w12;
reg [3:0] next_y_adj;
reg [3:0] next_ma;
reg [3:0] next_mb;
reg       next_pair_bad;
reg       next_wb_en;
reg       next_wb_ind;
reg       next_wb_bad;
reg [2:0] next_page;
reg       next_page_bad;
reg       next_dst_bad;

always @* begin
    next_src_am = am_decode(src_mode_i, src_ofs_form_i);
    next_dst_am = am_decode(dst_mode_i, dst_ofs_form_i);
    // Unused destination mode is only fatal when the instruction uses it
    next_dst_bad = dst_mode_used_i && (next_dst_am == `AM_UNUSED); // see RULE_03

    // Even codes up to 12 name a register pair, odd codes up to 13 its even register alone
    if (mul_dst_i[3:1] == 3'h7) begin
        next_mul_dst  = mul_dst_i[0] ? `MUL_ACC_B : `MUL_ACC_A; // see RULE_06
        next_mul_pair = 1'b0;
        next_mul_acc  = 1'b1;
    end else begin
        next_mul_dst  = {mul_dst_i[3:1], 1'b0}; // see RULE_06
        next_mul_pair = ~mul_dst_i[0];
        next_mul_acc  = 1'b0;
    end

    // X prefetch
    next_x_en  = (x_pf_op_i != {1'b0, `PF_NONE_CODE}); // see RULE_07
    next_x_reg = x_pf_op_i[3] ? `REG_W9 : `WORKING_REG_8; // see RULE_07 RULE_08 RULE_09
    next_x_w12 = (x_pf_op_i == {1'b1, `PF_OFS_CODE}); // see RULE_09
    next_x_adj = pf_adjust(x_pf_op_i[2:0]); // see RULE_08 RULE_09

    // Y prefetch; codes above 1100 are not defined and prefetch nothing
    next_y_en  = (y_pf_op_i != {1'b0, `PF_NONE_CODE}) &&
                 (y_pf_op_i <= {1'b1, `PF_OFS_CODE}); // see RULE_10
    next_y_reg = y_pf_op_i[3] ? `REG_W11 : `REG_W10; // see RULE_10 RULE_11
    next_y_w12 = (y_pf_op_i == {1'b1, `PF_OFS_CODE}); // see RULE_11
    next_y_adj = pf_adjust(y_pf_op_i[2:0]);

    // Multiplier operands
    next_pair_bad = 1'b0;
    if (square_form_i) begin
        next_ma = w4_to_w7(square_operand_field_i); // see RULE_14
        next_mb = w4_to_w7(square_operand_field_i);
    end else begin
        case (pair_operand_field_i)
            3'h0: begin
                next_ma = `REG_W4; // see RULE_15
                next_mb = `REG_W5;
            end
            3'h1: begin
                next_ma = `REG_W4;
                next_mb = `REG_W6;
            end
            3'h2: begin
                next_ma = `REG_W4;
                next_mb = `REG_W7;
            end
            3'h4: begin
                next_ma = `REG_W5;
                next_mb = `REG_W6;
            end
            3'h5: begin
                next_ma = `REG_W5;
                next_mb = `REG_W7;
            end
            3'h6: begin
                next_ma = `REG_W6;
                next_mb = `REG_W7;
            end
            default: begin
                next_ma       = `REG_W4;
                next_mb       = `REG_W4;
                next_pair_bad = mul_used_i; // see RULE_15 RULE_20
            end
        endcase
    end

    // Accumulator write-back
    next_wb_en  = 1'b0;
    next_wb_ind = 1'b0;
    next_wb_bad = 1'b0;
    case (writeback_select_field_i)
        `WB_DIRECT:   next_wb_en = 1'b1; // see RULE_16
        `WB_INDIRECT: begin
            next_wb_en  = 1'b1; // see RULE_16
            next_wb_ind = 1'b1;
        end
        `WB_NONE:     next_wb_en = 1'b0;
        default:      next_wb_bad = wb_used_i; // see RULE_16 RULE_20
    endcase

    // Page target, one-hot: read page, write page, table page
    next_page_bad = 1'b0;
    case (page_target_field_i)
        2'h0:    next_page = 3'h1; // see RULE_17
        2'h1:    next_page = 3'h2;
        2'h2:    next_page = 3'h4;
        default: begin
            next_page     = 3'h0;
            next_page_bad = page_used_i; // see RULE_17
        end
    endcase
end

wire [3:0] next_cause = {next_page_bad, next_wb_bad, next_pair_bad, next_dst_bad};
wire       next_ill   = do_dec & (|next_cause);

// ==========================================================
// Registered outputs
// Illegal words decode with all side effects suppressed so nothing commits
always @(posedge clk_i) begin
    if (rst_i) begin
        dec_valid_o     <= 1'b0;
        src_am_o        <= `AM_DIRECT;
        dst_am_o        <= `AM_DIRECT;
        base_reg_o      <= 4'h0;
        mul_dst_reg_o   <= 4'h0;
        mul_dst_pair_o  <= 1'b0;
        mul_dst_acc_o   <= 1'b0;
        x_pf_en_o       <= 1'b0;
        x_pf_addr_reg_o <= 4'h0;
        x_pf_add_w12_o  <= 1'b0;
        x_pf_adj_o      <= 4'h0;
        x_pf_dest_o     <= 4'h0;
        y_pf_en_o       <= 1'b0;
        y_pf_addr_reg_o <= 4'h0;
        y_pf_add_w12_o  <= 1'b0;
        y_pf_adj_o      <= 4'h0;
        y_pf_dest_o     <= 4'h0;
        mul_a_reg_o     <= 4'h0;
        mul_b_reg_o     <= 4'h0;
        wb_en_o         <= 1'b0;
        wb_indirect_o   <= 1'b0;
        wb_reg_o        <= 4'h0;
        wb_adj_o        <= 4'h0;
        page_reg_sel_o  <= 3'h0;
        acc_b_sel_o     <= 1'b0;
        reset_req_o     <= 1'b0;
    end else begin
        dec_valid_o <= do_dec & ~next_ill;
        reset_req_o <= next_ill; // see RULE_03 RULE_17 RULE_20
        if (do_dec) begin
            src_am_o        <= next_src_am;
            dst_am_o        <= next_dst_am;
            base_reg_o      <= base_sel_i; // see RULE_19
            mul_dst_reg_o   <= next_mul_dst;
            mul_dst_pair_o  <= next_mul_pair;
            mul_dst_acc_o   <= next_mul_acc;
            x_pf_en_o       <= next_x_en & ~next_ill;
            x_pf_addr_reg_o <= next_x_reg;
            x_pf_add_w12_o  <= next_x_w12;
            x_pf_adj_o      <= next_x_w12 ? 4'h0 : next_x_adj;
            x_pf_dest_o     <= w4_to_w7(x_prefetch_dest_field_i); // see RULE_12
            y_pf_en_o       <= next_y_en & ~next_ill;
            y_pf_addr_reg_o <= next_y_reg;
            y_pf_add_w12_o  <= next_y_w12;
            y_pf_adj_o      <= next_y_w12 ? 4'h0 : next_y_adj; // see RULE_11
            y_pf_dest_o     <= w4_to_w7(y_prefetch_dest_field_i); // see RULE_13
            mul_a_reg_o     <= next_ma;
            mul_b_reg_o     <= next_mb;
            wb_en_o         <= next_wb_en & wb_used_i & ~next_ill;
            wb_indirect_o   <= next_wb_ind;
            wb_reg_o        <= `WORKING_REG_13; // see RULE_16
            wb_adj_o        <= next_wb_ind ? `WB_STEP : 4'h0;
            page_reg_sel_o  <= next_ill ? 3'h0 : next_page;
            acc_b_sel_o     <= acc_sel_i; // see RULE_18
        end else begin
            x_pf_en_o      <= 1'b0;
            y_pf_en_o      <= 1'b0;
            wb_en_o        <= 1'b0;
            page_reg_sel_o <= 3'h0;
        end
    end
end

// ==========================================================
// Status: sticky causes and a saturating count of illegal words
wire ctrl_wr   = bus_write & (adr_i == `ADDR_CTRL) & sel_i[0];
wire status_wr = bus_write & (adr_i == `ADDR_STATUS) & sel_i[0];
wire count_wr  = bus_write & (adr_i == `ADDR_COUNT);

always @(posedge clk_i) begin
    if (rst_i) begin
        dec_en <= `CTRL_RESET;
    end else if (ctrl_wr) begin
        dec_en <= dat_i[`CTRL_EN_BIT];
    end
end

// A new cause in the clearing cycle survives the clear
always @(posedge clk_i) begin
    if (rst_i) begin
        ill_cause <= 4'h0;
    end else if (status_wr) begin
        ill_cause <= (ill_cause & ~dat_i[3:0]) | (next_ill ? next_cause : 4'h0);
    end else if (next_ill) begin
        ill_cause <= ill_cause | next_cause;
    end
end

// Saturates so a flood of bad words never wraps back to zero
always @(posedge clk_i) begin
    if (rst_i) begin
        ill_count <= 16'h0000;
    end else if (count_wr) begin
        ill_count <= 16'h0000;
    end else if (next_ill && ill_count != 16'hFFFF) begin
        ill_count <= ill_count + 16'h0001;
    end
end

// ==========================================================
// Wishbone answer: one wait state, unmapped reads return zero
always @(posedge clk_i) begin
    if (rst_i) begin
        ack_o <= 1'b0;
        dat_o <= 32'h00000000;
    end else begin
        ack_o <= bus_req;
        if (bus_req && !we_i) begin
            dat_o <= read_word(adr_i, dec_en, ill_cause, ill_count);
        end
    end
end

endmodule // operand_field_decoder
`default_nettype wire

// file: test/decoder_checker_sva.sv
// Port assertions for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module decoder_checker (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    input wire logic       dec_valid_i,
    input wire logic       dst_ofs_form_i,
    input wire logic       dst_mode_used_i,
    input wire logic [2:0] dst_mode_i,
    input wire logic [3:0] x_pf_op_i,
    input wire logic       page_used_i,
    input wire logic [1:0] page_target_field_i,
    input wire logic       acc_sel_i,
    input wire logic       dec_valid_o,
    input wire logic       reset_req_o,
    input wire logic       x_pf_en_o,
    input wire logic [3:0] x_pf_addr_reg_o,
    input wire logic [2:0] page_reg_sel_o,
    input wire logic       acc_b_sel_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ========
    // Steps
    sequence s_bus_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_dst_bad;
        (dec_valid_o || reset_req_o) && $past(dst_mode_used_i && !dst_ofs_form_i
            && dst_mode_i[2:1] == 2'h3);
    endsequence
    // ========
    // Properties
    a_ack_next: assert property (s_bus_req |=> ack_o) else $error("ack late");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_dec_cause: assert property (dec_valid_o || reset_req_o |-> $past(dec_valid_i))
        else $error("output without word");
    a_dst_unused: assert property (s_dst_bad |-> reset_req_o && !dec_valid_o)
        else $error("unused mode not reset");
    a_page_bad: assert property ((dec_valid_o || reset_req_o) && $past(page_used_i
        && page_target_field_i == 2'h3) |-> reset_req_o) else $error("page code kept");
    a_page_onehot: assert property (dec_valid_o && $past(page_used_i) |->
        page_reg_sel_o == (3'h1 << $past(page_target_field_i))) else $error("page sel");
    a_xpf_base: assert property (x_pf_en_o |->
        x_pf_addr_reg_o == ($past(x_pf_op_i[3]) ? 4'h9 : 4'h8)) else $error("x base");
    a_xpf_none: assert property (dec_valid_o && $past(x_pf_op_i) == 4'h4 |->
        !x_pf_en_o) else $error("x prefetch on");
    a_acc_sel: assert property (dec_valid_o |-> acc_b_sel_o == $past(acc_sel_i))
        else $error("acc select");
endmodule // decoder_checker
bind operand_field_decoder decoder_checker decoder_checker_inst (.*);
`default_nettype wire

// file: test/fetch_model.sv
// Fetch side model issuing one instruction word at a time
`timescale 1ns/1ps
`default_nettype none
// Outputs keep the decoder's input names so they wire up by name
module fetch_model (
    input  wire logic       clk_i,
    output logic       dec_valid_i = 1'h0,
    output logic       src_ofs_form_i = 1'h0,
    output logic       dst_ofs_form_i = 1'h0,
    output logic       dst_mode_used_i = 1'h0,
    output logic [2:0] src_mode_i = 3'h0,
    output logic [2:0] dst_mode_i = 3'h0,
    output logic [3:0] base_sel_i = 4'h0,
    output logic [3:0] mul_dst_i = 4'h0,
    output logic [3:0] x_pf_op_i = 4'h4,
    output logic [1:0] x_prefetch_dest_field_i = 2'h0,
    output logic [3:0] y_pf_op_i = 4'h4,
    output logic [1:0] y_prefetch_dest_field_i = 2'h0,
    output logic       square_form_i = 1'h1,
    output logic [1:0] square_operand_field_i = 2'h0,
    output logic [2:0] pair_operand_field_i = 3'h0,
    output logic       mul_used_i = 1'h0,
    output logic [1:0] writeback_select_field_i = 2'h2,
    output logic       wb_used_i = 1'h0,
    output logic [1:0] page_target_field_i = 2'h0,
    output logic       page_used_i = 1'h0,
    output logic       acc_sel_i = 1'h0
);
    // ========
    // Word issue
    // Legal defaults, one field set per word, so each fault is isolated
    task automatic send(input logic [3:0] f, input logic [7:0] v);
        @(posedge clk_i);
        src_ofs_form_i <= f == 4'h0 && v[3];
        src_mode_i <= f == 4'h0 ? v[2:0] : 3'h0;
        dst_ofs_form_i <= f == 4'h1 && v[3];
        dst_mode_used_i <= f == 4'h1;
        dst_mode_i <= f == 4'h1 ? v[2:0] : 3'h0;
        base_sel_i <= f == 4'h2 ? v[3:0] : 4'h0;
        mul_dst_i <= f == 4'h3 ? v[3:0] : 4'h0;
        x_pf_op_i <= f == 4'h4 ? v[3:0] : 4'h4;
        y_pf_op_i <= f == 4'h5 ? v[3:0] : 4'h4;
        x_prefetch_dest_field_i <= v[5:4];
        y_prefetch_dest_field_i <= v[5:4];
        square_form_i <= f != 4'h7;
        square_operand_field_i <= v[1:0];
        pair_operand_field_i <= v[2:0];
        mul_used_i <= f == 4'h3 || f == 4'h6 || f == 4'h7;
        writeback_select_field_i <= f == 4'h8 ? v[1:0] : 2'h2;
        wb_used_i <= f == 4'h8;
        page_target_field_i <= f == 4'h9 ? v[1:0] : 2'h0;
        page_used_i <= f == 4'h9;
        acc_sel_i <= f == 4'hA && v[0];
        dec_valid_i <= 1'h1;
        @(posedge clk_i);
        dec_valid_i <= 1'h0;
    endtask
endmodule // fetch_model
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, en, bad;
    logic [3:0]  adr_i, sel_i, c;
    logic [31:0] dat_i, dat_o, rd;
    logic        dec_valid_i, src_ofs_form_i, dst_ofs_form_i, dst_mode_used_i, square_form_i;
    logic        mul_used_i, wb_used_i, page_used_i, acc_sel_i;
    logic [2:0]  src_mode_i, dst_mode_i, pair_operand_field_i, am;
    logic [3:0]  base_sel_i, mul_dst_i, x_pf_op_i, y_pf_op_i;
    logic [1:0]  x_prefetch_dest_field_i, y_prefetch_dest_field_i, square_operand_field_i;
    logic [1:0]  writeback_select_field_i, page_target_field_i;
    logic        dec_valid_o, mul_dst_pair_o, mul_dst_acc_o, x_pf_en_o, x_pf_add_w12_o;
    logic        y_pf_en_o, y_pf_add_w12_o, wb_en_o, wb_indirect_o, acc_b_sel_o, reset_req_o;
    logic [2:0]  src_am_o, dst_am_o, page_reg_sel_o;
    logic [3:0]  base_reg_o, mul_dst_reg_o, x_pf_addr_reg_o, x_pf_adj_o, x_pf_dest_o;
    logic [3:0]  y_pf_addr_reg_o, y_pf_adj_o, y_pf_dest_o, mul_a_reg_o, mul_b_reg_o;
    logic [3:0]  wb_reg_o, wb_adj_o;
    logic [7:0]  pair_tab [8];
    int          errors, num_checks;

    operand_field_decoder operand_field_decoder_inst (.*);
    fetch_model fetch_model_inst (.*);

    always #12.5 clk_i = ~clk_i;

    // ========
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, we, a, 4'hF, d};
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
        if (n >= 20) errors++;
        rd = dat_o;
        {cyc_i, stb_i} <= 2'h0;
    endtask
    task automatic word(input logic [3:0] f, input logic [7:0] v, input logic b);
        fetch_model_inst.send(f, v);
        @(negedge clk_i);
        chk({dec_valid_o, reset_req_o}, {!b, b});
    endtask
    task automatic print_verdict;
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ========
    // Tests
    initial begin
        pair_tab = '{8'h45, 8'h46, 8'h47, 8'h00, 8'h56, 8'h57, 8'h67, 8'h00};
        {clk_i, rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {2'h1, 43'h0};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h1, 4'hC, 32'hFFFFFFFF);
        wb(1'h0, 4'h0, 32'h0);
        chk(rd, 32'h1);
        for (int a = 4; a < 16; a += 4) begin
            wb(1'h0, a[3:0], 32'h0);
            chk(rd, 32'h0);
        end
        for (int i = 0; i < 16; i++) begin
            am = (i[2:1] == 2'h3) ? (i[3] ? 3'h6 : 3'h7) : i[2:0];
            bad = !i[3] && i[2:1] == 2'h3;
            word(4'h0, i[7:0], 1'h0);
            chk(src_am_o, am);
            word(4'h1, i[7:0], bad);
            if (!bad) chk(dst_am_o, am);
            word(4'h2, i[7:0], 1'h0);
            chk(base_reg_o, i[3:0]);
            word(4'h3, i[7:0], 1'h0);
            chk({mul_dst_reg_o, mul_dst_pair_o, mul_dst_acc_o}, {i < 14 ? {i[3:1], 1'h0} :
                i[3:0], i < 14 && !i[0], i >= 14});
        end
        for (int i = 0; i < 64; i++) begin
            c = i[3:0];
            en = c[2:0] != 3'h4 || c == 4'hC;
            word(4'h4, i[7:0], 1'h0);
            chk(x_pf_en_o, en);
            if (en) chk({x_pf_addr_reg_o, x_pf_add_w12_o, x_pf_adj_o, x_pf_dest_o},
                {c[3] ? 4'h9 : 4'h8, c == 4'hC, c == 4'hC ? 4'h0 : {c[2:0], 1'h0},
                2'h1, i[5:4]});
            en = en && c < 4'hD;
            word(4'h5, i[7:0], 1'h0);
            chk(y_pf_en_o, en);
            if (en) chk({y_pf_addr_reg_o, y_pf_add_w12_o, y_pf_adj_o, y_pf_dest_o},
                {3'h5, c[3], c == 4'hC, c == 4'hC ? 4'h0 : {c[2:0], 1'h0},
                2'h1, i[5:4]});
        end
        for (int i = 0; i < 8; i++) begin
            bad = pair_tab[i] == 8'h00;
            word(4'h6, i[7:0], 1'h0);
            if (i < 4) chk({mul_a_reg_o, mul_b_reg_o}, {2'h1, i[1:0], 2'h1, i[1:0]});
            word(4'h7, i[7:0], bad);
            if (!bad) chk({mul_a_reg_o, mul_b_reg_o}, pair_tab[i]);
            if (i > 3) continue;
            word(4'h8, i[7:0], i == 3);
            chk(wb_en_o, i < 2);
            if (i < 2) chk({wb_indirect_o, wb_reg_o, wb_adj_o}, {i[0], 4'hD, 2'h0, i[0],
                1'h0});
            word(4'h9, i[7:0], i == 3);
            chk(page_reg_sel_o, i == 3 ? 3'h0 : 3'h1 << i);
            word(4'hA, i[7:0], 1'h0);
            chk(acc_b_sel_o, i[0]);
        end
        wb(1'h0, 4'h4, 32'h0);
        chk(rd, 32'hF);
        wb(1'h0, 4'h8, 32'h0);
        chk(rd, 32'h6);
        wb(1'h1, 4'h4, 32'hF);
        wb(1'h1, 4'h8, 32'h0);
        wb(1'h0, 4'h4, 32'h0);
        chk(rd, 32'h0);
        wb(1'h0, 4'h8, 32'h0);
        chk(rd, 32'h0);
        // Decode disabled: even an illegal word must pass silently
        wb(1'h1, 4'h0, 32'h0);
        fetch_model_inst.send(4'h9, 8'h03);
        @(negedge clk_i);
        chk({dec_valid_o, reset_req_o}, 2'h0);
        wb(1'h1, 4'h0, 32'h1);
        word(4'hA, 8'h01, 1'h0);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
